// file: rtl/ccs_pkg.sv
/*
 * Constants shared by the clock source select block: register map,
 * field positions, reset values, timing figures and switch states.
 * Assumes a 32-bit APB register bus and a 125 MHz pclk.
 */
package ccs_pkg;

   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
   localparam logic [ADDR_W-1:0] FLAG_ADDR = 8'h08;
   localparam logic [ADDR_W-1:0] MASK_ADDR = 8'h0C;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int CTRL_MCU_EN_BIT = 0;
   localparam int CTRL_DRV_LSB = 1;
   localparam int CTRL_KEEP_OFF_BIT = 3;
   localparam int STATUS_SRC_BIT = 0;
   localparam int STATUS_OK_BIT = 1;
   localparam int FLAG_CHG_BIT = 0;
   localparam int MASK_CHG_BIT = 0;

   // ************************************************************
   // Reset values and codes
   // ************************************************************
   localparam logic MCU_EN_RST = 1'b1;
   localparam logic [1:0] DRV_RST = 2'b00;
   localparam logic [1:0] DRV_HIGH_Z = 2'b10;
   localparam logic KEEP_OFF_RST = 1'b0;
   localparam logic MASK_RST = 1'b1;
   localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int PCLK_PERIOD_NS = 8;
   localparam int QUAL_EDGES_DEF = 256;
   localparam int LOSS_INT_EDGES = 2;

   // ************************************************************
   // Switch states
   // ************************************************************
   typedef enum logic [1:0] {
      SW_FOLLOW,
      SW_DRAIN,
      SW_ARM
   } ccs_sw_state_t;

endpackage

// file: rtl/ccs_switch.sv
/*
 * Glitch-free two-source clock switch, sampled on pclk.
 * Assumes both source levels are already synchronised to pclk.
 */
`timescale 1ns/1ps
`default_nettype none

module ccs_switch (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic int_clk,
   input wire logic xtal_clk,
   input wire logic want_xtal,
   output logic clk_out,
   output logic using_xtal
);
   import ccs_pkg::*;

   typedef struct packed {
      ccs_sw_state_t st;
      logic use_x;
      logic out;
   } ccs_sw_reg_t;

   ccs_sw_reg_t r;
   ccs_sw_reg_t next_r;
   logic cur;
   logic nw;

   // ************************************************************
   // Source hand-over
   // ************************************************************
   always_comb begin
      next_r = r;
      cur = r.use_x ? xtal_clk : int_clk;
      nw = r.use_x ? int_clk : xtal_clk;
      unique case (r.st)
         SW_FOLLOW: begin
            next_r.out = cur;
            if (want_xtal != r.use_x) begin
               next_r.st = SW_DRAIN;
            end
         end
         SW_DRAIN: begin
            next_r.out = cur;
            // Dead crystal never goes low again: cut at once
            if (!cur || (r.use_x && !want_xtal)) begin
               next_r.out = 1'b0; // Hold low phase
               next_r.st = SW_ARM;
            end
         end
         SW_ARM: begin
            next_r.out = 1'b0;
            if (want_xtal == r.use_x) begin
               // Back to old source only from its low phase
               if (!cur) begin
                  next_r.st = SW_FOLLOW;
               end
            end else if (!nw) begin
               next_r.use_x = ~r.use_x;
               next_r.st = SW_FOLLOW;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{st: SW_FOLLOW, use_x: 1'b0, out: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign clk_out = r.out;
   assign using_xtal = r.use_x;

endmodule

`default_nettype wire

// file: rtl/ccs_top.sv
/*
 * Clock source select: picks the internal oscillator or the crystal
 * as 32 kHz time base, switches without glitches, falls back on loss,
 * reports the source and gates the processor and peripheral clock
 * outputs. APB slave for its registers.
 * Assumes presetn is the backup-domain power-on reset, the sequencer
 * and state machine inputs are on pclk, the oscillator pins are not.
 */
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - No crystal: run from internal oscillator
// - Running crystal: everything runs from crystal
// - Output held steady during source change
// - Crystal stops: fall back to internal
// - Status bit: 0 internal, 1 crystal
// - Flag on change; interrupt if unmasked
// - Sequencer enables drivers; low-power-off programmable
// - Processor clock enable, resets to 1
// - Peripheral clock only in On state
// - Drive code 00 default, 10 high-Z
// - Keeps running on backup supply alone
// - Flag both directions, no debounce
module ccs_top #(
   parameter int QUAL_EDGES = ccs_pkg::QUAL_EDGES_DEF,
   parameter int QUAL_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ccs_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic internal_osc_in,
   input wire logic crystal_in,
   input wire logic seq_drivers_en,
   input wire logic state_on,
   input wire logic state_low_power_off,
   output logic processor_clock_out,
   output logic peripheral_clock_out,
   output logic peripheral_clock_oe_n,
   output logic [1:0] peripheral_clock_drive_sel,
   output logic clock_source_status,
   output logic irq
);
   import ccs_pkg::*;

   // ************************************************************
   // Elaboration checks
   // ************************************************************
   if (QUAL_EDGES < 2 || QUAL_EDGES >= (2 ** QUAL_W)) begin : g_bad_qual
      $error("QUAL_EDGES out of range for QUAL_W");
   end
   if (LOSS_INT_EDGES < 2 || LOSS_INT_EDGES > 3) begin : g_bad_loss
      $error("LOSS_INT_EDGES must be 2 or 3");
   end

   localparam logic [QUAL_W-1:0] QUAL_LAST = QUAL_W'(QUAL_EDGES - 1);
   localparam logic [1:0] LOSS_LAST = 2'(LOSS_INT_EDGES - 1);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic int_s1;
      logic int_s2;
      logic int_d;
      logic xt_s1;
      logic xt_s2;
      logic xt_d;
      logic [QUAL_W-1:0] qual_cnt;
      logic [1:0] miss_cnt;
      logic xtal_ok;
      logic mcu_en;
      logic [1:0] drv;
      logic keep_off;
      logic mask;
      logic flag;
      logic src_d;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      logic mcu_out;
      logic per_out;
      logic per_oe_n;
      logic [1:0] per_drv;
      logic src_out;
      logic irq;
   } ccs_reg_t;

   ccs_reg_t r;
   ccs_reg_t next_r;
   logic sw_clk;
   logic sw_xtal;
   logic access;
   logic rd_flag;
   logic mcu_drv_on;
   logic per_drv_on;

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      is_mapped = (a == CTRL_ADDR) || (a == STATUS_ADDR) ||
                  (a == FLAG_ADDR) || (a == MASK_ADDR);
   endfunction

   function automatic logic rise(input logic now, input logic was);
      rise = now & ~was;
   endfunction

   // ************************************************************
   // Glitch-free switch
   // ************************************************************
   ccs_switch u_switch (
      .pclk(pclk),
      .presetn(presetn),
      .int_clk(r.int_s2),
      .xtal_clk(r.xt_s2),
      .want_xtal(r.xtal_ok),
      .clk_out(sw_clk),
      .using_xtal(sw_xtal)
   );

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      next_r = r;
      access = psel & penable & ~r.pready;
      rd_flag = access & ~pwrite & (paddr == FLAG_ADDR);

      // Pin synchronisers
      next_r.int_s1 = internal_osc_in;
      next_r.int_s2 = r.int_s1;
      next_r.int_d = r.int_s2;
      next_r.xt_s1 = crystal_in;
      next_r.xt_s2 = r.xt_s1;
      next_r.xt_d = r.xt_s2;

      // Crystal qualification and loss watch
      if (rise(r.xt_s2, r.xt_d)) begin
         next_r.miss_cnt = 2'b00;
         if (r.qual_cnt == QUAL_LAST) begin
            next_r.xtal_ok = 1'b1;
         end else begin
            next_r.qual_cnt = r.qual_cnt + QUAL_W'(1);
         end
      end else if (rise(r.int_s2, r.int_d)) begin
         if (r.miss_cnt == LOSS_LAST) begin
            next_r.miss_cnt = 2'b00;
            next_r.qual_cnt = '0;
            next_r.xtal_ok = 1'b0;
         end else begin
            next_r.miss_cnt = r.miss_cnt + 2'b01;
         end
      end

      // Source change flag, set wins over read clear
      next_r.src_d = sw_xtal;
      if (rd_flag) begin
         next_r.flag = 1'b0;
      end
      if (sw_xtal != r.src_d) begin
         next_r.flag = 1'b1;
      end
      next_r.irq = next_r.flag & ~next_r.mask;

      // APB slave, one wait state
      next_r.pready = access;
      next_r.pslverr = 1'b0;
      if (access) begin
         next_r.pslverr = ~is_mapped(paddr);
         next_r.prdata = RDATA_NONE;
         if (pwrite) begin
            if (paddr == CTRL_ADDR) begin
               next_r.mcu_en = pwdata[CTRL_MCU_EN_BIT];
               next_r.drv = pwdata[CTRL_DRV_LSB +: 2];
               next_r.keep_off = pwdata[CTRL_KEEP_OFF_BIT];
            end else if (paddr == MASK_ADDR) begin
               next_r.mask = pwdata[MASK_CHG_BIT];
            end
         end else begin
            unique case (paddr)
               CTRL_ADDR: begin
                  next_r.prdata[CTRL_MCU_EN_BIT] = r.mcu_en;
                  next_r.prdata[CTRL_DRV_LSB +: 2] = r.drv;
                  next_r.prdata[CTRL_KEEP_OFF_BIT] = r.keep_off;
               end
               STATUS_ADDR: begin
                  next_r.prdata[STATUS_SRC_BIT] = sw_xtal;
                  next_r.prdata[STATUS_OK_BIT] = r.xtal_ok;
               end
               FLAG_ADDR: begin
                  next_r.prdata[FLAG_CHG_BIT] = r.flag;
               end
               MASK_ADDR: begin
                  next_r.prdata[MASK_CHG_BIT] = r.mask;
               end
               default: begin
                  next_r.prdata = RDATA_NONE;
               end
            endcase
         end
      end

      // Output drivers
      mcu_drv_on = seq_drivers_en & r.mcu_en &
                   (state_on | (state_low_power_off & r.keep_off));
      per_drv_on = seq_drivers_en & state_on &
                   (r.drv != DRV_HIGH_Z);
      next_r.mcu_out = mcu_drv_on & sw_clk;
      next_r.per_out = per_drv_on & sw_clk;
      next_r.per_oe_n = ~per_drv_on;
      next_r.per_drv = r.drv;
      next_r.src_out = sw_xtal;
   end

   // ************************************************************
   // Registers: cleared only by the backup-domain reset
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.mcu_en <= MCU_EN_RST;
         r.drv <= DRV_RST;
         r.keep_off <= KEEP_OFF_RST;
         r.mask <= MASK_RST;
         r.per_drv <= DRV_RST;
         r.per_oe_n <= 1'b1;
      end else begin
         r <= next_r; // No main-supply dependency
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign processor_clock_out = r.mcu_out;
   assign peripheral_clock_out = r.per_out;
   assign peripheral_clock_oe_n = r.per_oe_n;
   assign peripheral_clock_drive_sel = r.per_drv;
   assign clock_source_status = r.src_out;
   assign irq = r.irq;

endmodule

`default_nettype wire

// file: verif/ccs_top_asserts.sv
/* Concurrent checks on the ccs_top ports.
   Assumes ccs_pkg is compiled first; bound to every ccs_top. */
`timescale 1ns/1ps
`default_nettype none
module ccs_top_chk
   import ccs_pkg::*;
(
   input wire logic pclk, input wire logic presetn,
   input wire logic psel, input wire logic penable, input wire logic pwrite,
   input wire logic [ccs_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata, input wire logic [31:0] prdata,
   input wire logic pready, input wire logic pslverr,
   input wire logic internal_osc_in, input wire logic crystal_in,
   input wire logic seq_drivers_en, input wire logic state_on,
   input wire logic state_low_power_off, input wire logic processor_clock_out,
   input wire logic peripheral_clock_out,
   input wire logic peripheral_clock_oe_n,
   input wire logic [1:0] peripheral_clock_drive_sel,
   input wire logic clock_source_status, input wire logic irq
);
   localparam int MIN_RUN = 12;
   logic p_q, run_ok, mask_q, xs_q;
   logic [7:0] run_cnt, xs_cnt;
   wire logic wr_done = psel & penable & pready & pwrite;
   wire logic wr_take = psel & penable & ~pready & pwrite;
   wire logic ctrl_wr = wr_done & (paddr == CTRL_ADDR);
   wire logic fall = p_q & ~processor_clock_out;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p_q <= 1'b0;
         run_ok <= 1'b0;
         mask_q <= MASK_RST;
         xs_q <= 1'b0;
         run_cnt <= 8'h00;
         xs_cnt <= 8'h00;
      end else begin
         p_q <= processor_clock_out;
         run_cnt <= fall | ~p_q ? 8'h01 : run_cnt + {7'h00, run_cnt != 8'hFF};
         run_ok <= seq_drivers_en & state_on & (run_ok | fall) & ~ctrl_wr;
         xs_q <= crystal_in;
         xs_cnt <= (xs_q != crystal_in) ? 8'h00 : xs_cnt + {7'h00, xs_cnt != 8'hFF};
         // Mask follows the design's write edge
         if (wr_take && paddr == MASK_ADDR) begin
            mask_q <= pwdata[MASK_CHG_BIT];
         end
      end
   end
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   glitch_free_a: assert property (fall && run_ok |-> run_cnt >= MIN_RUN)
      else $error("short high phase on processor clock");
   loss_fallback_a: assert property (xs_cnt >= 8'hC8 |-> !clock_source_status)
      else $error("no fallback after crystal stop");
   status_read_a: assert property (pready && !pwrite && paddr == STATUS_ADDR
      && $stable(clock_source_status) |-> prdata[0] == clock_source_status)
      else $error("status read disagrees with source");
   change_irq_a: assert property ($changed(clock_source_status)
      && !mask_q |-> irq)
      else $error("no interrupt on source change");
   mask_quiet_a: assert property (mask_q && $past(mask_q) |-> !irq)
      else $error("interrupt while masked");
   proc_gate_a: assert property (!seq_drivers_en [*6] |-> !processor_clock_out)
      else $error("processor clock without drivers");
   per_gate_a: assert property (!state_on [*6] |-> !peripheral_clock_out)
      else $error("peripheral clock outside On");
   drv_follow_a: assert property (wr_done && paddr == CTRL_ADDR |-> ##2
      peripheral_clock_drive_sel == $past(pwdata[2:1], 2))
      else $error("drive code not applied");
   hiz_code_a: assert property ((peripheral_clock_drive_sel == DRV_HIGH_Z) [*2]
      |-> peripheral_clock_oe_n && !peripheral_clock_out)
      else $error("pad driven in high-Z code");
   cover property ($rose(clock_source_status));
   cover property ($fell(clock_source_status));
   cover property ($rose(irq));
endmodule
bind ccs_top ccs_top_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .internal_osc_in, .crystal_in,
   .seq_drivers_en, .state_on, .state_low_power_off, .processor_clock_out,
   .peripheral_clock_out, .peripheral_clock_oe_n, .peripheral_clock_drive_sel,
   .clock_source_status, .irq);
`default_nettype wire

// file: verif/ccs_clk_sink.sv
/* Receiver model: counts clean rising edges at both clock inputs.
   Assumes outputs change on pclk; a released pad counts nothing. */
`timescale 1ns/1ps
`default_nettype none
module ccs_clk_sink (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic processor_clock_out,
   input wire logic peripheral_clock_out,
   input wire logic peripheral_clock_oe_n,
   output var int proc_edges,
   output var int per_edges
);
   logic proc_q, per_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         proc_q <= 1'b0;
         per_q <= 1'b0;
         proc_edges <= 0;
         per_edges <= 0;
      end else begin
         proc_q <= processor_clock_out;
         per_q <= peripheral_clock_out & ~peripheral_clock_oe_n;
         proc_edges <= proc_edges + int'(processor_clock_out & ~proc_q);
         per_edges <= per_edges + int'(peripheral_clock_out & ~peripheral_clock_oe_n & ~per_q);
      end
   end
endmodule
`default_nettype wire

// file: verif/tb.sv
/* Self-checking bench for ccs_top with receiver model.
   Assumes package, design, checker and sink compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ccs_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq;
   logic internal_osc_in, crystal_in, seq_drivers_en, state_on, xtal_run;
   logic state_low_power_off, processor_clock_out, peripheral_clock_out;
   logic peripheral_clock_oe_n, clock_source_status;
   logic [1:0] peripheral_clock_drive_sel;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [23:0] g;
   logic [23:0] tbl [5] = '{24'h101100, 24'h101910, 24'h101800, 24'h010100, 24'h110111};
   int fail_count, total_checks, cyc, ic, xc, dp, dq, proc_edges, per_edges;
   int m_ctrl, m_mask, m_flag;
   int seed = 32'h424A;
   ccs_top #(.QUAL_EDGES(4)) u_ccs_top (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .internal_osc_in,
      .crystal_in, .seq_drivers_en, .state_on, .state_low_power_off,
      .processor_clock_out, .peripheral_clock_out, .peripheral_clock_oe_n,
      .peripheral_clock_drive_sel, .clock_source_status, .irq);
   ccs_clk_sink u_ccs_clk_sink (.pclk, .presetn, .processor_clock_out,
      .peripheral_clock_out, .peripheral_clock_oe_n, .proc_edges, .per_edges);
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      ic <= (ic == 19) ? 0 : ic + 1;
      xc <= (xc == 15) ? 0 : xc + 1;
      if (ic == 19) begin
         internal_osc_in <= ~internal_osc_in;
      end
      if (xc == 15 && xtal_run) begin
         crystal_in <= ~crystal_in;
      end
      if (cyc == 20000) begin
         fail_count++;
         $display("MISMATCH %0t timeout", $time);
         give_verdict;
      end
   end
   task automatic give_verdict;
      if (fail_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input int e);
      apb(1'b0, a, $random(seed));
      chk(rd, e, "read data");
   endtask
   task automatic wr(input logic [7:0] a, input int d);
      apb(1'b1, a, ($random(seed) & 32'hFFFF_FFF0) | d);
   endtask
   task automatic meas;
      repeat (10) @(posedge pclk);
      dp = proc_edges;
      dq = per_edges;
      repeat (100) @(posedge pclk);
      dp = proc_edges - dp;
      dq = per_edges - dq;
   endtask
   task automatic sw(input logic v);
      xtal_run <= v;
      while (clock_source_status !== v) begin
         @(posedge pclk);
      end
      m_flag = 1;
      repeat (2) @(posedge pclk);
      chk(irq, m_flag & ~m_mask, "interrupt");
      rdc(FLAG_ADDR, m_flag);
      m_flag = 0;
   endtask
   initial begin
      {presetn, psel, penable, pwrite, xtal_run, state_low_power_off} = 6'h00;
      {internal_osc_in, crystal_in, paddr, pwdata} = 42'h0;
      {seq_drivers_en, state_on} = 2'b11;
      m_ctrl = 1;
      m_mask = 1;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdc(CTRL_ADDR, m_ctrl);
      rdc(MASK_ADDR, m_mask);
      rdc(STATUS_ADDR, 0);
      rdc(8'h10, 0);
      chk(err, 1, "no error on unmapped read");
      wr(8'h10, 0);
      chk(err, 1, "no error on unmapped write");
      rdc(CTRL_ADDR, m_ctrl);
      wr(STATUS_ADDR, 3);
      chk(err, 0, "error on status write");
      rdc(STATUS_ADDR, 0);
      meas;
      chk(dp > 0, 1, "no internal clock");
      m_mask = 0;
      wr(MASK_ADDR, m_mask);
      xtal_run <= 1'b1;
      repeat (80) @(posedge pclk);
      chk(clock_source_status, 0, "early switch");
      for (int i = 0; i < 3; i++) begin
         m_mask = (i == 2);
         wr(MASK_ADDR, m_mask);
         sw(i != 1);
      end
      rdc(STATUS_ADDR, 3);
      rdc(FLAG_ADDR, 0);
      chk(irq, 0, "interrupt after clear");
      for (int c = 0; c < 4; c++) begin
         m_ctrl = c * 2 + 1;
         wr(CTRL_ADDR, m_ctrl);
         meas;
         chk(peripheral_clock_drive_sel, c, "drive code");
         chk(peripheral_clock_oe_n, c == 2, "pad enable");
         chk(dq > 0, c != 2, "peripheral clock");
         rdc(CTRL_ADDR, m_ctrl);
      end
      for (int k = 0; k < 5; k++) begin
         g = tbl[k];
         seq_drivers_en <= g[20];
         state_on <= g[16];
         state_low_power_off <= g[12];
         m_ctrl = int'(g[11:8]);
         wr(CTRL_ADDR, m_ctrl);
         meas;
         chk(dp > 0, g[4], "processor clock");
         chk(dq > 0, g[0], "peripheral clock");
      end
      give_verdict;
   end
endmodule
`default_nettype wire
